// ### core/aotr_fuse_rom.sv
// Fuse storage image holding power-up trim defaults, one word per slot.
// Read data is registered: valid the cycle after the address is presented.
`timescale 1ns/1ps
module aotr_fuse_rom (
    // Clock
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Read port
    input wire logic [2:0] rd_addr_i,
    output logic [15:0] rd_data_o
);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= aotr_pkg::TRIM_RESET;
        end else if (ce_i) begin
            unique case (rd_addr_i)
                aotr_pkg::SLOT_ADC3_C: rd_data_o <= aotr_pkg::FUSE_ADC3_C;
                aotr_pkg::SLOT_ADC3_D: rd_data_o <= aotr_pkg::FUSE_ADC3_D;
                aotr_pkg::SLOT_ADC4: rd_data_o <= aotr_pkg::FUSE_ADC4;
                aotr_pkg::SLOT_ADC5: rd_data_o <= aotr_pkg::FUSE_ADC5;
                aotr_pkg::SLOT_ADC0_G: rd_data_o <= aotr_pkg::FUSE_ADC0_G;
                aotr_pkg::SLOT_ADC1_G: rd_data_o <= aotr_pkg::FUSE_ADC1_G;
                aotr_pkg::SLOT_ADC2_A_G: rd_data_o <= aotr_pkg::FUSE_ADC2_A_G;
                default: rd_data_o <= aotr_pkg::TRIM_RESET;
            endcase
        end
    end

endmodule // aotr_fuse_rom

// ### core/aotr_trim_regs.sv
// Offset and fine gain trim registers behind a classic Wishbone slave.
// Assumes the converter cores pulse conv_start_i on sys_clk_i at each conversion.
`timescale 1ns/1ps
module aotr_trim_regs (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter core side
    input wire logic conv_start_i,
    output logic [11:0] adc3_c_input_offset_trim_o,
    output logic [11:0] adc3_d_input_offset_trim_o,
    output logic [11:0] adc4_offset_trim_o,
    output logic [11:0] adc5_offset_trim_o,
    output logic [4:0] adc0_fine_gain_trim_o,
    output logic [4:0] adc1_fine_gain_trim_o,
    output logic [4:0] adc2_a_input_fine_gain_trim_o
);

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    // Returns {hit, slot} for a word index
    function automatic logic [3:0] decode_slot(input logic [9:0] idx);
        logic [3:0] res;
        res = 4'h0;
        unique case (idx)
            aotr_pkg::IDX_ADC3_C_OFS: res = {1'b1, aotr_pkg::SLOT_ADC3_C};
            aotr_pkg::IDX_ADC3_D_OFS: res = {1'b1, aotr_pkg::SLOT_ADC3_D};
            aotr_pkg::IDX_ADC4_OFS: res = {1'b1, aotr_pkg::SLOT_ADC4};
            aotr_pkg::IDX_ADC5_OFS: res = {1'b1, aotr_pkg::SLOT_ADC5};
            aotr_pkg::IDX_ADC0_GAIN: res = {1'b1, aotr_pkg::SLOT_ADC0_G};
            aotr_pkg::IDX_ADC1_GAIN: res = {1'b1, aotr_pkg::SLOT_ADC1_G};
            aotr_pkg::IDX_ADC2_A_GAIN: res = {1'b1, aotr_pkg::SLOT_ADC2_A_G};
            default: res = 4'h0;
        endcase
        return res;
    endfunction

    // Gain slots are byte registers; upper byte does not exist
    function automatic logic [15:0] slot_mask(input logic [2:0] slot);
        return (slot >= aotr_pkg::SLOT_ADC0_G) ? aotr_pkg::GAIN_REG_MASK : aotr_pkg::OFS_REG_MASK;
    endfunction

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic [15:0] trim_reg [aotr_pkg::REG_COUNT];
    logic [2:0] load_slot_reg;
    logic [15:0] rom_rdata;
    logic loaded_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    aotr_pkg::aotr_load_e ld_state_reg;

    logic [9:0] word_idx;
    logic [3:0] dec;
    logic bus_req;
    logic bus_fire;
    logic wr_fire;
    logic rd_fire;
    logic ld_ready;

    assign word_idx = wb_adr_i[11:2];
    assign dec = decode_slot(word_idx);
    assign ld_ready = (ld_state_reg == aotr_pkg::LD_READY);
    assign bus_req = wb_cyc_i && wb_stb_i;
    // Requests stall while the fuse image is loading
    assign bus_fire = bus_req && !ack_reg && ld_ready;
    assign wr_fire = bus_fire && wb_we_i;
    assign rd_fire = bus_fire && !wb_we_i;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= bus_fire;
        end
    end

    // ==========================================================
    // Fuse preload sequencer
    // ==========================================================
    aotr_fuse_rom u_fuse_rom (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .rd_addr_i(load_slot_reg),
        .rd_data_o(rom_rdata)
    );

    logic reload_req;
    assign reload_req = wr_fire && (word_idx == aotr_pkg::IDX_TRIM_CTRL) && wb_sel_i[0]
                        && wb_dat_i[aotr_pkg::CTRL_RELOAD_BIT];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ld_state_reg <= aotr_pkg::LD_FETCH;
            load_slot_reg <= 3'h0;
        end else if (ce_i) begin
            unique case (ld_state_reg)
                aotr_pkg::LD_FETCH: ld_state_reg <= aotr_pkg::LD_STORE;
                aotr_pkg::LD_STORE: begin
                    if (load_slot_reg == aotr_pkg::SLOT_LAST) begin
                        ld_state_reg <= aotr_pkg::LD_READY;
                    end else begin
                        ld_state_reg <= aotr_pkg::LD_FETCH;
                    end
                    load_slot_reg <= load_slot_reg + 3'h1;
                end
                aotr_pkg::LD_READY: begin
                    if (reload_req) begin
                        ld_state_reg <= aotr_pkg::LD_FETCH;
                        load_slot_reg <= 3'h0;
                    end
                end
                default: ld_state_reg <= aotr_pkg::LD_FETCH;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            loaded_reg <= 1'b0;
        end else if (ce_i) begin
            if (reload_req) begin
                loaded_reg <= 1'b0;
            end else if (ld_state_reg == aotr_pkg::LD_STORE && load_slot_reg == aotr_pkg::SLOT_LAST) begin
                loaded_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Trim register array
    // ==========================================================
    // Reserved bits are stored and read back so software can verify them
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < aotr_pkg::REG_COUNT; i++) begin
                trim_reg[i] <= aotr_pkg::TRIM_RESET;
            end
        end else if (ce_i) begin
            for (int i = 0; i < aotr_pkg::REG_COUNT; i++) begin
                if (ld_state_reg == aotr_pkg::LD_STORE && load_slot_reg == 3'(i)) begin
                    trim_reg[i] <= rom_rdata & slot_mask(3'(i));
                end else if (wr_fire && dec[3] && dec[2:0] == 3'(i)) begin
                    if (wb_sel_i[0]) begin
                        trim_reg[i][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1] && slot_mask(3'(i)) == aotr_pkg::OFS_REG_MASK) begin
                        trim_reg[i][15:8] <= wb_dat_i[15:8];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            if (rd_fire) begin
                if (dec[3]) begin
                    rdata_reg <= {16'h0000, trim_reg[dec[2:0]]};
                end else if (word_idx == aotr_pkg::IDX_TRIM_STATUS) begin
                    rdata_reg <= {30'h0000_0000, !ld_ready, loaded_reg};
                end else begin
                    rdata_reg <= 32'h0000_0000;
                end
            end
        end
    end

    // ==========================================================
    // Core-facing trim outputs
    // ==========================================================
    // Updated only at a conversion start so a write mid-conversion cannot
    // corrupt the sample in flight; costs one conversion of latency.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            adc3_c_input_offset_trim_o <= 12'h000;
            adc3_d_input_offset_trim_o <= 12'h000;
            adc4_offset_trim_o <= 12'h000;
            adc5_offset_trim_o <= 12'h000;
            adc0_fine_gain_trim_o <= 5'h00;
            adc1_fine_gain_trim_o <= 5'h00;
            adc2_a_input_fine_gain_trim_o <= 5'h00;
        end else if (ce_i && conv_start_i) begin
            // Low field bits taken, upper bits dropped, no sign handling
            adc3_c_input_offset_trim_o <= trim_reg[aotr_pkg::SLOT_ADC3_C][aotr_pkg::OFS_MSB:0];
            adc3_d_input_offset_trim_o <= trim_reg[aotr_pkg::SLOT_ADC3_D][aotr_pkg::OFS_MSB:0];
            adc4_offset_trim_o <= trim_reg[aotr_pkg::SLOT_ADC4][aotr_pkg::OFS_MSB:0];
            adc5_offset_trim_o <= trim_reg[aotr_pkg::SLOT_ADC5][aotr_pkg::OFS_MSB:0];
            adc0_fine_gain_trim_o <= trim_reg[aotr_pkg::SLOT_ADC0_G][aotr_pkg::GAIN_MSB:0];
            adc1_fine_gain_trim_o <= trim_reg[aotr_pkg::SLOT_ADC1_G][aotr_pkg::GAIN_MSB:0];
            adc2_a_input_fine_gain_trim_o <= trim_reg[aotr_pkg::SLOT_ADC2_A_G][aotr_pkg::GAIN_MSB:0];
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence load_step_s;
        ce_i && ld_state_reg == aotr_pkg::LD_FETCH ##1 ce_i && ld_state_reg == aotr_pkg::LD_STORE;
    endsequence

    sequence conv_edge_s;
        ce_i && conv_start_i;
    endsequence

    ack_single_pulse_a: assert property (ce_i && ack_reg |=> !ack_reg)
        else $error("ack held longer than one cycle");
    load_stall_a: assert property (ce_i && bus_req && !ld_ready |=> !ack_reg)
        else $error("ack given while fuse load runs");
    fuse_slot_load_a: assert property (
        load_step_s and (load_slot_reg == aotr_pkg::SLOT_ADC3_C)[*2]
        |=> trim_reg[aotr_pkg::SLOT_ADC3_C] == aotr_pkg::FUSE_ADC3_C)
        else $error("fuse default not loaded into first slot");
    adc3c_apply_a: assert property (conv_edge_s
        |=> adc3_c_input_offset_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC3_C][11:0]))
        else $error("core 3 C offset not applied");
    adc3d_apply_a: assert property (conv_edge_s
        |=> adc3_d_input_offset_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC3_D][11:0]))
        else $error("core 3 D offset not applied");
    adc4_apply_a: assert property (conv_edge_s
        |=> adc4_offset_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC4][11:0]))
        else $error("core 4 offset not applied");
    adc5_apply_a: assert property (conv_edge_s
        |=> adc5_offset_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC5][11:0]))
        else $error("core 5 offset not applied");
    adc0_fine_gain_trim_apply_a: assert property (conv_edge_s
        |=> adc0_fine_gain_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC0_G][4:0]))
        else $error("core 0 gain not applied");
    adc1_fine_gain_trim_apply_a: assert property (conv_edge_s
        |=> adc1_fine_gain_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC1_G][4:0]))
        else $error("core 1 gain not applied");
    adc2_a_input_fine_gain_trim_apply_a: assert property (conv_edge_s
        |=> adc2_a_input_fine_gain_trim_o == $past(trim_reg[aotr_pkg::SLOT_ADC2_A_G][4:0]))
        else $error("core 2 A gain not applied");
    ofs_write_a: assert property (
        ce_i && wr_fire && word_idx == aotr_pkg::IDX_ADC4_OFS && wb_sel_i[1:0] == 2'b11
        ##1 ce_i && conv_start_i
        |=> {4'h0, adc4_offset_trim_o} == $past(wb_dat_i[15:0], 2) - {$past(wb_dat_i[15:12], 2), 12'h000})
        else $error("offset write not carried unsigned to core 4");
    trim_hold_a: assert property (!(ce_i && conv_start_i)
        |=> $stable({adc3_c_input_offset_trim_o, adc4_offset_trim_o, adc0_fine_gain_trim_o}))
        else $error("trim output changed outside conversion start");

    // ==========================================================
    // Bus and preload assertions
    // ==========================================================
    // Read-side checks look one cycle after the take, where rdata_reg has settled
    sequence bus_take_s;
        ce_i && bus_fire;
    endsequence

    sequence reg_write_s;
        ce_i && wr_fire && dec[3];
    endsequence

    sequence last_store_s;
        ce_i && ld_state_reg == aotr_pkg::LD_STORE && load_slot_reg == aotr_pkg::SLOT_LAST;
    endsequence

    ack_after_take_a: assert property (bus_take_s |=> ack_reg)
        else $error("taken request not acked next cycle");
    ack_needs_take_a: assert property (ce_i && !bus_fire |=> !ack_reg)
        else $error("ack without a taken request");
    low_byte_write_a: assert property (
        reg_write_s ##0 wb_sel_i[0]
        |=> trim_reg[$past(dec[2:0])][7:0] == $past(wb_dat_i[7:0]))
        else $error("low byte write did not land");
    high_byte_write_a: assert property (
        reg_write_s ##0 (wb_sel_i[1] && dec[2:0] == aotr_pkg::SLOT_ADC3_C)
        |=> trim_reg[aotr_pkg::SLOT_ADC3_C][15:8] == $past(wb_dat_i[15:8]))
        else $error("core 3 C offset high byte did not land");
    // Gain slots are byte wide, so sel[1] must never reach their upper half
    gain_byte_only_a: assert property (
        trim_reg[aotr_pkg::SLOT_ADC0_G][15:8] == 8'h00 && trim_reg[aotr_pkg::SLOT_ADC1_G][15:8] == 8'h00
        && trim_reg[aotr_pkg::SLOT_ADC2_A_G][15:8] == 8'h00)
        else $error("gain register grew an upper byte");
    trim_read_a: assert property (
        ce_i && rd_fire && word_idx == aotr_pkg::IDX_ADC4_OFS
        |=> rdata_reg == {16'h0000, $past(trim_reg[aotr_pkg::SLOT_ADC4])})
        else $error("core 4 offset read back wrong");
    unmapped_read_a: assert property (
        ce_i && rd_fire && !dec[3] && word_idx != aotr_pkg::IDX_TRIM_STATUS
        |=> rdata_reg == 32'h0000_0000)
        else $error("unmapped read returned data");
    status_read_a: assert property (
        ce_i && rd_fire && word_idx == aotr_pkg::IDX_TRIM_STATUS
        |=> rdata_reg[aotr_pkg::STAT_LOADED_BIT] == $past(loaded_reg)
        && rdata_reg[aotr_pkg::STAT_BUSY_BIT] == $past(!ld_ready))
        else $error("status read wrong");
    reload_start_a: assert property (
        ce_i && reload_req
        |=> ld_state_reg == aotr_pkg::LD_FETCH && load_slot_reg == 3'h0 && !loaded_reg)
        else $error("reload did not restart the preload");
    load_finish_a: assert property (last_store_s |=> ld_ready && loaded_reg)
        else $error("preload did not finish after last slot");
    loaded_hold_a: assert property (ce_i && loaded_reg && !reload_req |=> loaded_reg)
        else $error("loaded flag dropped without a reload");
    fuse_gain_load_a: assert property (
        load_step_s and (load_slot_reg == aotr_pkg::SLOT_ADC2_A_G)[*2]
        |=> trim_reg[aotr_pkg::SLOT_ADC2_A_G] == aotr_pkg::FUSE_ADC2_A_G)
        else $error("fuse default not loaded into last slot");
    // A dropped write must leave the trims untouched; two slots stand for all
    unmapped_write_a: assert property (ce_i && wr_fire && !dec[3]
        |=> $stable(trim_reg[aotr_pkg::SLOT_ADC4]) && $stable(trim_reg[aotr_pkg::SLOT_ADC2_A_G]))
        else $error("unmapped write changed a trim");

endmodule // aotr_trim_regs

// ### pkg/aotr_pkg.sv
// Shared constants for the converter offset and fine gain trim bank.
// Assumes a 32-bit classic Wishbone slave; byte address is four times the index.
package aotr_pkg;

    // ==========================================================
    // Register indices (byte address = index * 4)
    // ==========================================================
    localparam int REG_COUNT = 7;
    localparam logic [9:0] IDX_ADC3_C_OFS = 10'h338;
    localparam logic [9:0] IDX_ADC3_D_OFS = 10'h33A;
    localparam logic [9:0] IDX_ADC4_OFS = 10'h33C;
    localparam logic [9:0] IDX_ADC5_OFS = 10'h33E;
    localparam logic [9:0] IDX_ADC0_GAIN = 10'h360;
    localparam logic [9:0] IDX_ADC1_GAIN = 10'h361;
    localparam logic [9:0] IDX_ADC2_A_GAIN = 10'h362;
    localparam logic [9:0] IDX_TRIM_CTRL = 10'h370;
    localparam logic [9:0] IDX_TRIM_STATUS = 10'h371;

    // ==========================================================
    // Slot numbers inside the trim array
    // ==========================================================
    localparam logic [2:0] SLOT_ADC3_C = 3'h0;
    localparam logic [2:0] SLOT_ADC3_D = 3'h1;
    localparam logic [2:0] SLOT_ADC4 = 3'h2;
    localparam logic [2:0] SLOT_ADC5 = 3'h3;
    localparam logic [2:0] SLOT_ADC0_G = 3'h4;
    localparam logic [2:0] SLOT_ADC1_G = 3'h5;
    localparam logic [2:0] SLOT_ADC2_A_G = 3'h6;
    localparam logic [2:0] SLOT_LAST = 3'h6;

    // ==========================================================
    // Field layout and reset values
    // ==========================================================
    localparam int OFS_MSB = 11;
    localparam int GAIN_MSB = 4;
    localparam logic [15:0] OFS_REG_MASK = 16'hFFFF;
    localparam logic [15:0] GAIN_REG_MASK = 16'h00FF;
    localparam logic [15:0] TRIM_RESET = 16'h0000;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_LOADED_BIT = 0;

    // ==========================================================
    // Fuse contents (plain defaults, replaced by real fuse data)
    // ==========================================================
    localparam logic [15:0] FUSE_ADC3_C = 16'h0801;
    localparam logic [15:0] FUSE_ADC3_D = 16'h0802;
    localparam logic [15:0] FUSE_ADC4 = 16'h0803;
    localparam logic [15:0] FUSE_ADC5 = 16'h0804;
    localparam logic [15:0] FUSE_ADC0_G = 16'h0011;
    localparam logic [15:0] FUSE_ADC1_G = 16'h0012;
    localparam logic [15:0] FUSE_ADC2_A_G = 16'h0013;

    typedef enum logic [1:0] {
        LD_FETCH = 2'b00,
        LD_STORE = 2'b01,
        LD_READY = 2'b10
    } aotr_load_e;

endpackage

// ### verification/tb_adc_offset_gain_trim_regs.sv
// Self-checking bench for the offset and fine gain trim register bank.
// Assumes the single-clock design with its classic Wishbone slave and conv_start_i pulses.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_adc_offset_gain_trim_regs;
    // ==========================================================
    // Signals and design
    // ==========================================================
    logic sys_clk_i;
    logic rst_n_i;
    logic ce_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic conv_start_i;
    logic [11:0] adc3_c_input_offset_trim;
    logic [11:0] adc3_d_input_offset_trim;
    logic [11:0] adc4_offset_trim;
    logic [11:0] adc5_offset_trim;
    logic [4:0] adc0_fine_gain_trim;
    logic [4:0] adc1_fine_gain_trim;
    logic [4:0] adc2_a_input_fine_gain_trim;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [11:0] adr_tab [7] = '{12'hCE0, 12'hCE8, 12'hCF0, 12'hCF8, 12'hD80, 12'hD84, 12'hD88};
    logic [15:0] fuse_tab [7] = '{aotr_pkg::FUSE_ADC3_C, aotr_pkg::FUSE_ADC3_D, aotr_pkg::FUSE_ADC4,
        aotr_pkg::FUSE_ADC5, aotr_pkg::FUSE_ADC0_G, aotr_pkg::FUSE_ADC1_G, aotr_pkg::FUSE_ADC2_A_G};
    // Extreme and mid-range field values with reserved bits kept at zero
    logic [15:0] new_tab [7] = '{16'h0ABC, 16'h0FFF, 16'h0123, 16'h0800, 16'h001F, 16'h0001, 16'h0010};

    always #2 sys_clk_i = ~sys_clk_i;

    aotr_trim_regs DUT (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .conv_start_i(conv_start_i),
        .adc3_c_input_offset_trim_o(adc3_c_input_offset_trim),
        .adc3_d_input_offset_trim_o(adc3_d_input_offset_trim),
        .adc4_offset_trim_o(adc4_offset_trim),
        .adc5_offset_trim_o(adc5_offset_trim),
        .adc0_fine_gain_trim_o(adc0_fine_gain_trim),
        .adc1_fine_gain_trim_o(adc1_fine_gain_trim),
        .adc2_a_input_fine_gain_trim_o(adc2_a_input_fine_gain_trim)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [15:0] trim_out(input int i);
        case (i)
            0: return {4'h0, adc3_c_input_offset_trim};
            1: return {4'h0, adc3_d_input_offset_trim};
            2: return {4'h0, adc4_offset_trim};
            3: return {4'h0, adc5_offset_trim};
            4: return {11'h000, adc0_fine_gain_trim};
            5: return {11'h000, adc1_fine_gain_trim};
            default: return {11'h000, adc2_a_input_fine_gain_trim};
        endcase
    endfunction

    // Only the field reaches the core; offsets are 12 bits, gains 5 bits
    function automatic logic [15:0] field(input logic [15:0] v, input int i);
        return (i < 4) ? (v & 16'h0FFF) : (v & 16'h001F);
    endfunction

    task automatic print_verdict;
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One classic cycle; waits for ack under a bound, covers the preload stall too
    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            print_verdict;
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
        end
    endtask

    task automatic pulse_conv;
        @(posedge sys_clk_i);
        conv_start_i <= 1'b1;
        @(posedge sys_clk_i);
        conv_start_i <= 1'b0;
        #1;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        sys_clk_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        conv_start_i = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK(trim_out(2), 16'h0000)
        // Requests raised during preload must wait, then see the fuse image
        for (int i = 0; i < 7; i++) begin
            wb_xfer(1'b0, adr_tab[i], 32'h0);
            `CHK(rd, {16'h0000, fuse_tab[i]})
        end
        wb_xfer(1'b0, 12'hDC4, 32'h0);
        `CHK(rd[0], 1'b1)
        pulse_conv;
        for (int i = 0; i < 7; i++) begin
            `CHK(trim_out(i), field(fuse_tab[i], i))
        end
        for (int i = 0; i < 7; i++) begin
            wb_xfer(1'b1, adr_tab[i], {16'h0000, new_tab[i]});
        end
        for (int i = 0; i < 7; i++) begin
            wb_xfer(1'b0, adr_tab[i], 32'h0);
            `CHK(rd, {16'h0000, new_tab[i]})
            `CHK(trim_out(i), field(fuse_tab[i], i))
        end
        pulse_conv;
        for (int i = 0; i < 7; i++) begin
            `CHK(trim_out(i), field(new_tab[i], i))
        end
        // Unmapped word next to the gain block: write dropped, read zero
        wb_xfer(1'b1, 12'hD8C, 32'h0000_001F);
        wb_xfer(1'b0, 12'hD8C, 32'h0);
        `CHK(rd, 32'h0000_0000)
        wb_xfer(1'b0, adr_tab[6], 32'h0);
        `CHK(rd, {16'h0000, new_tab[6]})
        // Reload from fuse, then prove core 3 C keeps its old offset trim while frozen
        wb_xfer(1'b1, 12'hDC0, 32'h0000_0001);
        wb_xfer(1'b0, adr_tab[0], 32'h0);
        `CHK(rd, {16'h0000, fuse_tab[0]})
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        pulse_conv;
        `CHK(trim_out(0), field(new_tab[0], 0))
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        pulse_conv;
        for (int i = 0; i < 7; i++) begin
            `CHK(trim_out(i), field(fuse_tab[i], i))
        end
        // Cores convert every cycle across a write: the new value lands on the next conversion
        @(posedge sys_clk_i);
        conv_start_i <= 1'b1;
        wb_xfer(1'b1, adr_tab[2], 32'h0000_0456);
        conv_start_i <= 1'b0;
        #1;
        `CHK(trim_out(2), 16'h0456)
        print_verdict;
    end

    initial begin
        #200000;
        failures++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        print_verdict;
    end
endmodule // tb_adc_offset_gain_trim_regs
